/* glc_regs.sv */
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// [RQ1] Gauge mode bit 0 enables the charge estimator when set, reset zero.
// [RQ2] Gauge mode bit 1 selects low-power sleep operation when set, reset zero.
// [RQ3] Gauge mode bit 2 picks a 5 min (0) or 20 min (1) sleep refresh.
// [RQ4] Writing one to clear bit 7 zeroes level and both voltage readbacks; a valid estimate in the same cycle is stored instead.
// [RQ5] Boost enable drives the boost output only in standalone boost mode.
// [RQ6] Sink enables for channels two to five switch each sink on or off.
// [RQ7] A sink enable is ignored while its channel belongs to the group.
// [RQ8] Charge level reads as a 7-bit percentage limited to 0 to 100.
// [RQ9] Voltage reads split as bits 12:5 high and bits 4:0 in low 7:3.
// [RQ10] Unused bits read zero and ignore writes; the clear bit reads zero.
module glc_regs
  import glc_pkg::*;
#(
  parameter longint SLEEP_SHORT_CYCLES = GLC_SLEEP_SHORT_CYC,
  parameter longint SLEEP_LONG_CYCLES  = GLC_SLEEP_LONG_CYC
)
(
  // Clock and reset
  input  wire logic                         I_REF_CLK,
  input  wire logic                         I_RST_B,
  // Register access from the serial host interface
  input  wire glc_req_t                     I_REQ,
  output var  logic [7:0]                   O_RDATA,
  // Estimator results and boost configuration
  input  wire glc_est_t                     I_EST,
  input  wire logic                         I_BOOST_STANDALONE,
  input  wire logic [GLC_EN_SINK_COUNT-1:0] I_SINK_GROUPED,
  // Controls
  output var  logic                         O_GAUGE_ENABLE,
  output var  logic                         O_GAUGE_SLEEP,
  output var  logic                         O_SLEEP_LONG_SEL,
  output var  logic                         O_SLEEP_REFRESH,
  output var  logic                         O_READBACK_CLEAR,
  output var  logic                         O_BOOST_ON,
  output var  logic [GLC_EN_SINK_COUNT-1:0] O_SINK_ON,
  output var  logic                         O_GROUP_ENABLE
);

  // Elaboration checks; the counter is sized for the longest interval
  if (SLEEP_SHORT_CYCLES < 64'd1)
  begin : g_short_bad
    $error("glc_regs: short sleep interval must be at least one cycle");
  end
  if (SLEEP_LONG_CYCLES < 64'd1)
  begin : g_long_bad
    $error("glc_regs: long sleep interval must be at least one cycle");
  end
  if (SLEEP_SHORT_CYCLES >= (64'd1 << GLC_CNT_WIDTH))
  begin : g_short_wide
    $error("glc_regs: short sleep interval exceeds the counter");
  end
  if (SLEEP_LONG_CYCLES >= (64'd1 << GLC_CNT_WIDTH))
  begin : g_long_wide
    $error("glc_regs: long sleep interval exceeds the counter");
  end

  localparam logic [GLC_CNT_WIDTH-1:0] SHORT_LAST =
    GLC_CNT_WIDTH'(SLEEP_SHORT_CYCLES - 64'd1);
  localparam logic [GLC_CNT_WIDTH-1:0] LONG_LAST =
    GLC_CNT_WIDTH'(SLEEP_LONG_CYCLES - 64'd1);

  glc_state_t s_q;
  glc_state_t s_d;

  always_comb
  begin
    logic                     clr;
    logic [GLC_CNT_WIDTH-1:0] last;
    logic                     sleep_run;
    clr       = 1'b0;
    last      = '0;
    sleep_run = 1'b0;
    s_d  = s_q;
    s_d.clear_pulse  = 1'b0;
    s_d.refresh_tick = 1'b0;

    // Writes; reserved bits are dropped
    if (I_REQ.wr)
    begin
      case (I_REQ.addr)
        GLC_ADDR_GAUGE_MODE:
        begin
          s_d.gm = I_REQ.wdata[GLC_GM_WIDTH-1:0]; // [RQ1] [RQ2] [RQ3] [RQ10]
        end
        GLC_ADDR_CLEAR:
        begin
          // Write-only strobe; nothing of it is stored
          clr = I_REQ.wdata[GLC_CLEAR_BIT]; // [RQ4]
        end
        GLC_ADDR_ENABLES:
        begin
          s_d.en = I_REQ.wdata[GLC_EN_WIDTH-1:0]; // [RQ6] [RQ10]
        end
        default:
        begin
          // Readback and unmapped offsets ignore writes
          s_d.gm = s_q.gm; // [RQ10]
        end
      endcase
    end

    // A fresh estimate in the clear cycle survives, so no reading is lost
    if (clr)
    begin
      s_d.level       = GLC_LEVEL_RESET; // [RQ4]
      s_d.volt        = GLC_VOLT_RESET; // [RQ4]
      s_d.clear_pulse = 1'b1;
    end
    if (I_EST.valid)
    begin
      // Clamp keeps a runaway estimate inside the percentage range
      if (I_EST.level > GLC_LEVEL_MAX)
      begin
        s_d.level = GLC_LEVEL_MAX; // [RQ8]
      end
      else
      begin
        s_d.level = I_EST.level; // [RQ8]
      end
      s_d.volt = I_EST.volt_mv; // [RQ9]
    end

    // Reads return the state before any write in the same cycle
    if (I_REQ.rd)
    begin
      case (I_REQ.addr)
        GLC_ADDR_CHARGE_LEVEL:
        begin
          s_d.rdata = {1'b0, s_q.level}; // [RQ8]
        end
        GLC_ADDR_VOLT_HIGH:
        begin
          s_d.rdata = s_q.volt[12:5]; // [RQ9]
        end
        GLC_ADDR_VOLT_LOW:
        begin
          // No latching between the halves; a new estimate can tear them
          s_d.rdata = {s_q.volt[4:0], 3'h0}; // [RQ9]
        end
        GLC_ADDR_GAUGE_MODE:
        begin
          s_d.rdata = {5'h00, s_q.gm}; // [RQ10]
        end
        GLC_ADDR_ENABLES:
        begin
          s_d.rdata = {2'h0, s_q.en}; // [RQ10]
        end
        default:
        begin
          // Clear strobe and unmapped offsets read zero
          s_d.rdata = 8'h00; // [RQ4] [RQ10]
        end
      endcase
    end

    // Outputs
    // Boost enable only reaches the output in standalone mode
    s_d.boost_on = s_d.en[GLC_EN_BOOST_BIT] & I_BOOST_STANDALONE; // [RQ5]
    // Grouped channels follow only the backlight group, so mask their bit
    for (int k = 0; k < GLC_EN_SINK_COUNT; k++)
    begin
      s_d.sink_on[k] = s_d.en[GLC_EN_SINK_LSB + k]
                       & ~I_SINK_GROUPED[k]; // [RQ6] [RQ7]
    end

    // Sleep refresh timer; restarts whenever sleep operation is left
    last = s_q.gm[GLC_GM_INTERVAL_BIT] ? LONG_LAST : SHORT_LAST; // [RQ3]
    sleep_run = s_q.gm[GLC_GM_ENABLE_BIT]
                & s_q.gm[GLC_GM_SLEEP_BIT]; // [RQ1] [RQ2]
    // Counter starts from zero on the edge the bits are set, so the first tick
    // comes one full interval later, the same as every later tick
    if (!sleep_run)
    begin
      s_d.cnt = '0;
    end
    else if (s_q.cnt >= last)
    begin
      s_d.cnt          = '0;
      s_d.refresh_tick = 1'b1; // [RQ3]
    end
    else
    begin
      s_d.cnt = s_q.cnt + GLC_CNT_WIDTH'(1);
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      s_q              <= '0;
      s_q.gm           <= GLC_GM_RESET; // [RQ1] [RQ2] [RQ3]
      s_q.en           <= GLC_EN_RESET; // [RQ6]
      s_q.level        <= GLC_LEVEL_RESET;
      s_q.volt         <= GLC_VOLT_RESET;
      s_q.rdata        <= 8'h00;
      s_q.boost_on     <= 1'b0;
      s_q.sink_on      <= '0;
      s_q.clear_pulse  <= 1'b0;
      s_q.refresh_tick <= 1'b0;
      s_q.cnt          <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign O_RDATA          = s_q.rdata;
  assign O_GAUGE_ENABLE   = s_q.gm[GLC_GM_ENABLE_BIT];
  assign O_GAUGE_SLEEP    = s_q.gm[GLC_GM_SLEEP_BIT];
  assign O_SLEEP_LONG_SEL = s_q.gm[GLC_GM_INTERVAL_BIT];
  assign O_SLEEP_REFRESH  = s_q.refresh_tick;
  assign O_READBACK_CLEAR = s_q.clear_pulse;
  assign O_BOOST_ON       = s_q.boost_on;
  assign O_SINK_ON        = s_q.sink_on;
  assign O_GROUP_ENABLE   = s_q.en[GLC_EN_GROUP_BIT];

endmodule // glc_regs

`default_nettype wire

/* glc_pkg.sv */
`default_nettype none

package glc_pkg;

  // Register offsets
  localparam logic [7:0] GLC_ADDR_CHARGE_LEVEL = 8'h21;
  localparam logic [7:0] GLC_ADDR_VOLT_HIGH    = 8'h22;
  localparam logic [7:0] GLC_ADDR_VOLT_LOW     = 8'h23;
  localparam logic [7:0] GLC_ADDR_GAUGE_MODE   = 8'h24;
  localparam logic [7:0] GLC_ADDR_CLEAR        = 8'h25;
  localparam logic [7:0] GLC_ADDR_ENABLES      = 8'h26;

  // Gauge mode control fields
  localparam int GLC_GM_ENABLE_BIT   = 0;
  localparam int GLC_GM_SLEEP_BIT    = 1;
  localparam int GLC_GM_INTERVAL_BIT = 2;
  localparam int GLC_GM_WIDTH        = 3;

  // Clear register field
  localparam int GLC_CLEAR_BIT = 7;

  // Boost and sink enable fields
  localparam int GLC_EN_GROUP_BIT  = 0;
  localparam int GLC_EN_SINK_LSB   = 1;
  localparam int GLC_EN_SINK_COUNT = 4;
  localparam int GLC_EN_BOOST_BIT  = 5;
  localparam int GLC_EN_WIDTH      = 6;

  // Readback fields
  localparam int         GLC_LEVEL_WIDTH = 7;
  localparam logic [6:0] GLC_LEVEL_MAX   = 7'h64;
  localparam int         GLC_VOLT_WIDTH  = 13;
  localparam int         GLC_VOLT_LOW_W  = 5;

  // Reset values
  localparam logic [2:0]  GLC_GM_RESET    = 3'h0;
  localparam logic [5:0]  GLC_EN_RESET    = 6'h00;
  localparam logic [6:0]  GLC_LEVEL_RESET = 7'h00;
  localparam logic [12:0] GLC_VOLT_RESET  = 13'h0000;

  // Sleep refresh intervals
  localparam longint GLC_CLK_HZ         = 64'd50_000_000;
  localparam longint GLC_SLEEP_SHORT_MIN = 64'd5;
  localparam longint GLC_SLEEP_LONG_MIN  = 64'd20;
  localparam longint GLC_SLEEP_SHORT_CYC =
    GLC_SLEEP_SHORT_MIN * 64'd60 * GLC_CLK_HZ;
  localparam longint GLC_SLEEP_LONG_CYC  =
    GLC_SLEEP_LONG_MIN * 64'd60 * GLC_CLK_HZ;
  localparam int GLC_CNT_WIDTH = 36;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } glc_req_t;

  typedef struct packed {
    logic                       valid;
    logic [GLC_LEVEL_WIDTH-1:0] level;
    logic [GLC_VOLT_WIDTH-1:0]  volt_mv;
  } glc_est_t;

  typedef struct packed {
    logic [GLC_GM_WIDTH-1:0]      gm;
    logic [GLC_EN_WIDTH-1:0]      en;
    logic [GLC_LEVEL_WIDTH-1:0]   level;
    logic [GLC_VOLT_WIDTH-1:0]    volt;
    logic [7:0]                   rdata;
    logic                         boost_on;
    logic [GLC_EN_SINK_COUNT-1:0] sink_on;
    logic                         clear_pulse;
    logic                         refresh_tick;
    logic [GLC_CNT_WIDTH-1:0]     cnt;
  } glc_state_t;

endpackage

`default_nettype wire

/* glc_regs_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module glc_regs_sva
  import glc_pkg::*;
(
  input wire logic       I_REF_CLK, I_RST_B, I_BOOST_STANDALONE,
  input wire logic       O_GAUGE_ENABLE, O_GAUGE_SLEEP, O_SLEEP_LONG_SEL,
  input wire logic       O_SLEEP_REFRESH, O_READBACK_CLEAR, O_BOOST_ON,
  input wire logic [3:0] I_SINK_GROUPED, O_SINK_ON,
  input wire logic [7:0] O_RDATA,
  input wire glc_req_t   I_REQ
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_wr(a); I_REQ.wr && I_REQ.addr == a; endsequence
  sequence s_rd(a); I_REQ.rd && I_REQ.addr == a; endsequence
  property p_gm; s_wr(8'h24) |=> $past(I_REQ.wdata[2:0]) ==
    {O_SLEEP_LONG_SEL, O_GAUGE_SLEEP, O_GAUGE_ENABLE}; endproperty
  a_gm: assert property (p_gm) else $error("gauge mode");
  property p_clr; O_READBACK_CLEAR == $past(I_REQ.wr && I_REQ.wdata[7]
    && I_REQ.addr == 8'h25); endproperty
  a_clr: assert property (p_clr) else $error("clear pulse");
  property p_bst; !I_BOOST_STANDALONE |=> !O_BOOST_ON; endproperty
  a_bst: assert property (p_bst) else $error("boost gate");
  property p_sg; 1 |=> !(O_SINK_ON & $past(I_SINK_GROUPED)); endproperty
  a_sg: assert property (p_sg) else $error("grouped sink on");
  property p_sw; s_wr(8'h26) |=>
    O_SINK_ON == $past(I_REQ.wdata[4:1] & ~I_SINK_GROUPED); endproperty
  a_sw: assert property (p_sw) else $error("sink enables");
  property p_lvl; s_rd(8'h21) |=> O_RDATA <= 8'h64; endproperty
  a_lvl: assert property (p_lvl) else $error("level range");
  property p_rz; s_rd(8'h25) |=> O_RDATA == 8'h00; endproperty
  a_rz: assert property (p_rz) else $error("clear reads");
  // Tick is registered, so it answers to the mode bits one edge earlier
  property p_ref; O_SLEEP_REFRESH |->
    $past(O_GAUGE_ENABLE && O_GAUGE_SLEEP); endproperty
  a_ref: assert property (p_ref) else $error("refresh out");
endmodule // glc_regs_sva
bind glc_regs glc_regs_sva u_sva (.*);
`default_nettype wire

/* glc_regs_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module glc_regs_bench
  import glc_pkg::*;
();
  localparam int SHORT = 10, LONG = 40;
  logic       clk = 1'b0, rst_b = 1'b0, stand = 1'b0;
  logic       gen, gsl, glo, tick, bon, gon, rclr;
  logic [3:0] grp = 4'h0, son;
  logic [7:0] rdata;
  glc_req_t   req = '0;
  glc_est_t   est = '0;
  int         n_mismatch = 0, checked = 0, n;
  always #10 clk = ~clk;
  glc_regs #(.SLEEP_SHORT_CYCLES(SHORT), .SLEEP_LONG_CYCLES(LONG)) u_dut (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .I_REQ(req), .O_RDATA(rdata),
    .I_EST(est), .I_BOOST_STANDALONE(stand), .I_SINK_GROUPED(grp),
    .O_GAUGE_ENABLE(gen), .O_GAUGE_SLEEP(gsl), .O_SLEEP_LONG_SEL(glo),
    .O_SLEEP_REFRESH(tick), .O_READBACK_CLEAR(rclr), .O_BOOST_ON(bon),
    .O_SINK_ON(son), .O_GROUP_ENABLE(gon));
  task automatic end_sim();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    checked++;
    if (s !== e)
      $display("[ERR] %s exp %h got %h", nm, e, s);
    n_mismatch += int'(s !== e);
  endtask
  // Gap cycle after each strobe keeps one assignment per time step
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    req <= '{w, !w, a, d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    if (!w)
      chk("rdata", d, rdata);
  endtask
  // Falling-edge sampling so the one-cycle tick is settled
  task automatic tk();
    n = 0;
    do
      @(negedge clk) n++;
    while (tick !== 1'b1 && n < 99);
    n_mismatch += int'(n == 99);
    if (n == 99)
      end_sim();
    @(posedge clk);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    acc(0, 8'h24, 8'h00);
    acc(0, 8'h26, 8'h00);
    chk("ctl", 8'h00, {glo, gsl, gen, son, bon});
    acc(1, 8'h24, 8'hFF);
    acc(0, 8'h24, 8'h07);
    for (int i = 0; i < 2; i++)
    begin
      acc(1, 8'h24, {5'h00, i[0], 2'h3});
      tk();
      tk();
      chk("period", i[0] ? LONG[7:0] : SHORT[7:0], n[7:0]);
    end
    acc(1, 8'h24, 8'h00);
    est <= '{1'b1, 7'h7F, 13'h1ABC};
    @(posedge clk);
    est.valid <= 1'b0;
    acc(0, 8'h21, 8'h64);
    acc(0, 8'h22, 8'hD5);
    acc(0, 8'h23, 8'hE0);
    acc(1, 8'h25, 8'h7F);
    acc(0, 8'h21, 8'h64);
    req <= '{1'b1, 1'b0, 8'h25, 8'h80};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk("clr", 8'h01, {7'h00, rclr});
    @(posedge clk);
    acc(0, 8'h21, 8'h00);
    acc(0, 8'h23, 8'h00);
    acc(0, 8'h25, 8'h00);
    grp <= 4'h5;
    acc(1, 8'h26, 8'hFF);
    acc(0, 8'h26, 8'h3F);
    chk("en", 8'h15, {2'b00, bon, son, gon});
    stand <= 1'b1;
    grp <= 4'h0;
    repeat (2) @(posedge clk);
    chk("en", 8'h3F, {2'b00, bon, son, gon});
    acc(0, 8'h30, 8'h00);
    end_sim();
  end
endmodule // glc_regs_bench
`default_nettype wire
